// [ssirq_pkg.sv]
package ssirq_pkg;

    // register indexes; byte address on the bus is four times the index
    localparam logic [31:0] IDX_GEN_STATUS = 32'hFFFE1029;
    localparam logic [31:0] IDX_SCSI_CTRL = 32'hFFFE102A;
    localparam logic [31:0] IDX_SLAVE_BASE = 32'hFFFE102B;
    localparam logic [31:0] IDX_IRQ_STATUS = 32'hFFFE102C;
    localparam logic [31:0] IDX_IRQ_MASK = 32'hFFFE102D;
    localparam logic [31:0] IDX_GLOBAL_CTRL = 32'hFFFE1027;

    // general status field positions
    localparam int GS_PARITY_BIT = 0;
    localparam int GS_POWER_BIT = 1;

    // scsi port interrupt control field positions
    localparam int SC_LEVEL_LSB = 0;
    localparam int SC_LEVEL_W = 3;
    localparam int SC_ENABLE_BIT = 3;
    localparam int SC_DRIVE_BIT = 4;
    localparam int SC_SENSE_BIT = 5;
    localparam int SC_RST_IRQ_BIT = 6;
    localparam int SC_PORT_IRQ_BIT = 7;

    // slave base field positions
    localparam int SB_SEL_LSB = 0;
    localparam int SB_SEL_W = 5;
    localparam int SB_WAIT_BIT = 5;
    localparam int SB_NET_LSB = 6;

    // interrupt status and mask layout
    localparam int IS_PARITY_BIT = 0;
    localparam int IS_SCSI_RST_BIT = 1;
    localparam int IS_CHIP_BIT = 2;
    localparam int IS_W = 3;

    // global control layout
    localparam int GC_GATE_BIT = 4;

    // onboard memory span is 2**MEM_SPAN_LOG2 bytes
    localparam int MEM_SPAN_LOG2 = 22;

    // reset values
    localparam logic [7:0] RST_SCSI_CTRL = 8'h00;
    localparam logic [7:0] RST_SLAVE_BASE = 8'h00;
    localparam logic [IS_W-1:0] RST_IRQ_MASK = 3'h0;
    localparam logic RST_GATE = 1'b0;

endpackage

// [ssirq_rst_sync.sv]
`timescale 1ns/100ps
`default_nettype none
// releases an active-low async reset in step with the clock
module ssirq_rst_sync (
    // clock and raw reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // synchronised reset
    output logic o_rst_n
);
    logic meta_q;

    // assert at once, release after two edges to avoid a metastable release
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q <= 1'b0;
            o_rst_n <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            o_rst_n <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [ssirq_sticky_bit.sv]
`timescale 1ns/100ps
`default_nettype none
// sticky flag: set by hardware, cleared by software; set beats clear
module ssirq_sticky_bit #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // set and clear requests
    input wire logic i_set,
    input wire logic i_clr,
    // flag
    output logic o_q
);
    // an event landing on the clear cycle is kept, never lost
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_q <= RST_VAL;
        end else if (i_set) begin
            o_q <= 1'b1;
        end else if (i_clr) begin
            o_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [ssirq_top.sv]
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module ssirq_top (
    // clock and resets
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_por_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    // board events
    input wire logic i_mem_parity_fault,
    input wire logic i_scsi_bus_reset_sense,
    input wire logic i_scsi_chip_irq,
    // scsi bus reset drive
    output logic o_scsi_bus_reset_drive,
    // interrupt requests
    output logic [2:0] o_scsi_irq_level,
    output logic o_irq,
    // slave window
    output logic [31:0] o_win_start,
    output logic [31:0] o_win_last,
    output logic o_locked_cycle_wait_ctl,
    output logic [1:0] o_net_dma_addr_hi
);
    // released copies of the system and power-on resets
    logic rst_n;
    logic por_rst_n;

    // every flop runs from the released copies of the resets
    ssirq_rst_sync u_rst_sync (
        .i_clk(i_clk),
        .i_arst_n(i_rst_n),
        .o_rst_n(rst_n)
    );
    ssirq_rst_sync u_por_sync (
        .i_clk(i_clk),
        .i_arst_n(i_por_n),
        .o_rst_n(por_rst_n)
    );

    // ---- apb decode ----
    logic setup_w;
    logic access_w;
    logic wr_w;
    logic hit_gen_w;
    logic hit_scsi_w;
    logic hit_base_w;
    logic hit_ists_w;
    logic hit_mask_w;
    logic hit_gctl_w;
    logic mapped_w;
    logic [7:0] wbyte_w;

    // byte address is index times four, taken modulo the 32-bit bus
    assign setup_w = i_psel & ~i_penable;
    assign access_w = i_psel & i_penable & o_pready;
    assign wr_w = access_w & i_pwrite & ~o_pslverr;
    assign hit_gen_w = i_paddr == {ssirq_pkg::IDX_GEN_STATUS[29:0], 2'b00};
    assign hit_scsi_w = i_paddr == {ssirq_pkg::IDX_SCSI_CTRL[29:0], 2'b00};
    assign hit_base_w = i_paddr == {ssirq_pkg::IDX_SLAVE_BASE[29:0], 2'b00};
    assign hit_ists_w = i_paddr == {ssirq_pkg::IDX_IRQ_STATUS[29:0], 2'b00};
    assign hit_mask_w = i_paddr == {ssirq_pkg::IDX_IRQ_MASK[29:0], 2'b00};
    assign hit_gctl_w = i_paddr == {ssirq_pkg::IDX_GLOBAL_CTRL[29:0], 2'b00};
    assign mapped_w = hit_gen_w | hit_scsi_w | hit_base_w | hit_ists_w | hit_mask_w
        | hit_gctl_w;
    assign wbyte_w = i_pwdata[7:0];

    // ---- control registers ----
    logic [7:0] scsi_ctrl_q;
    logic [7:0] slave_base_q;
    logic [ssirq_pkg::IS_W-1:0] irq_mask_q;
    logic gate_q;

    // only writable fields are stored; the rest never take write data
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            scsi_ctrl_q <= ssirq_pkg::RST_SCSI_CTRL;
            slave_base_q <= ssirq_pkg::RST_SLAVE_BASE;
            irq_mask_q <= ssirq_pkg::RST_IRQ_MASK;
            gate_q <= ssirq_pkg::RST_GATE;
        end else begin
            if (wr_w && hit_scsi_w) begin
                scsi_ctrl_q <= {3'h0, wbyte_w[4:0]};
            end
            if (wr_w && hit_base_w) begin
                slave_base_q <= wbyte_w;
            end
            if (wr_w && hit_mask_w) begin
                irq_mask_q <= wbyte_w[ssirq_pkg::IS_W-1:0];
            end
            if (wr_w && hit_gctl_w) begin
                gate_q <= wbyte_w[ssirq_pkg::GC_GATE_BIT];
            end
        end
    end

    logic [2:0] level_w;
    logic enable_w;

    // level and enable fields read straight out of the stored byte
    assign level_w = scsi_ctrl_q[ssirq_pkg::SC_LEVEL_LSB +: ssirq_pkg::SC_LEVEL_W];
    assign enable_w = scsi_ctrl_q[ssirq_pkg::SC_ENABLE_BIT];

    // ---- general status flags ----
    logic par_clr_w;
    logic pwr_clr_w;
    logic par_flag_q;
    logic pwr_flag_q;

    // a zero written leaves the flag where it was
    assign par_clr_w = wr_w & hit_gen_w & wbyte_w[ssirq_pkg::GS_PARITY_BIT];
    assign pwr_clr_w = wr_w & hit_gen_w & wbyte_w[ssirq_pkg::GS_POWER_BIT];

    // parity flag sits on the system reset; an event beats a same-cycle clear
    ssirq_sticky_bit #(.RST_VAL(1'b0)) u_par_flag (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_set(i_mem_parity_fault),
        .i_clr(par_clr_w),
        .o_q(par_flag_q)
    );

    // sits on the power-on reset alone, so a plain system reset keeps it
    ssirq_sticky_bit #(.RST_VAL(1'b1)) u_pwr_flag (
        .i_clk(i_clk),
        .i_rst_n(por_rst_n),
        .i_set(1'b0),
        .i_clr(pwr_clr_w),
        .o_q(pwr_flag_q)
    );

    // ---- scsi reset interrupt ----
    logic qual_w;
    logic qual_q;
    logic rst_edge_w;
    logic rst_irq_clr_w;
    logic rst_irq_q;
    logic port_irq_w;

    // remembers enable-and-reset so that only its rising edge latches
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            qual_q <= 1'b0;
        end else begin
            qual_q <= qual_w;
        end
    end

    assign qual_w = enable_w & i_scsi_bus_reset_sense;
    assign rst_edge_w = qual_w & ~qual_q;
    assign rst_irq_clr_w = (wr_w & hit_scsi_w & wbyte_w[ssirq_pkg::SC_RST_IRQ_BIT])
        | ~enable_w;
    assign port_irq_w = rst_irq_q | i_scsi_chip_irq;

    // disabling the interrupt holds the latch clear until the next edge
    ssirq_sticky_bit #(.RST_VAL(1'b0)) u_rst_irq (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_set(rst_edge_w),
        .i_clr(rst_irq_clr_w),
        .o_q(rst_irq_q)
    );

    // ---- interrupt status and mask ----
    logic chip_q;
    logic [ssirq_pkg::IS_W-1:0] ev_w;
    logic [ssirq_pkg::IS_W-1:0] ev_clr_w;
    logic [ssirq_pkg::IS_W-1:0] ists_q;

    // previous chip request, so only its rising edge counts as an event
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_q <= 1'b0;
        end else begin
            chip_q <= i_scsi_chip_irq;
        end
    end

    // events are the parity fault, the enabled scsi reset edge and a chip request edge
    assign ev_w = {i_scsi_chip_irq & ~chip_q, rst_edge_w, i_mem_parity_fault};
    assign ev_clr_w = (wr_w & hit_ists_w) ? wbyte_w[ssirq_pkg::IS_W-1:0]
        : {ssirq_pkg::IS_W{1'b0}};

    // one sticky cell per status bit; a clear never swallows a same-cycle event
    genvar gi;
    generate
        for (gi = 0; gi < ssirq_pkg::IS_W; gi++) begin : g_ists
            ssirq_sticky_bit #(.RST_VAL(1'b0)) u_ev (
                .i_clk(i_clk),
                .i_rst_n(rst_n),
                .i_set(ev_w[gi]),
                .i_clr(ev_clr_w[gi]),
                .o_q(ists_q[gi])
            );
        end
    endgenerate

    // ---- outputs toward the board ----
    // the level output stays zero without the gate, so no request can escape
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_scsi_bus_reset_drive <= 1'b0;
            o_scsi_irq_level <= 3'h0;
            o_irq <= 1'b0;
        end else begin
            o_scsi_bus_reset_drive <= scsi_ctrl_q[ssirq_pkg::SC_DRIVE_BIT];
            o_scsi_irq_level <= (port_irq_w && gate_q) ? level_w : 3'h0;
            o_irq <= gate_q & |(ists_q & irq_mask_q);
        end
    end

    // ---- slave window ----
    logic [4:0] win_sel_w;
    logic [31:0] win_start_w;
    logic [31:0] win_span_w;

    // the window start is the select times the span, a plain shift
    assign win_sel_w = slave_base_q[ssirq_pkg::SB_SEL_LSB +: ssirq_pkg::SB_SEL_W];
    assign win_start_w = 32'(win_sel_w) << ssirq_pkg::MEM_SPAN_LOG2;
    assign win_span_w = 32'h1 << ssirq_pkg::MEM_SPAN_LOG2;

    // registered so that the window outputs come straight from flops
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_win_start <= 32'h0;
            o_win_last <= 32'h0;
            o_locked_cycle_wait_ctl <= 1'b0;
            o_net_dma_addr_hi <= 2'h0;
        end else begin
            o_win_start <= win_start_w;
            o_win_last <= win_start_w + win_span_w - 32'h1;
            o_locked_cycle_wait_ctl <= slave_base_q[ssirq_pkg::SB_WAIT_BIT];
            o_net_dma_addr_hi <= slave_base_q[ssirq_pkg::SB_NET_LSB +: 2];
        end
    end

    // ---- read mux ----
    logic [7:0] gen_rd_w;
    logic [7:0] scsi_rd_w;
    logic [7:0] ists_rd_w;
    logic [7:0] mask_rd_w;
    logic [7:0] gctl_rd_w;
    logic [7:0] rd_w;

    // register views; positions with no field read as zero
    assign gen_rd_w = {6'h00, pwr_flag_q, par_flag_q};
    assign ists_rd_w = {5'h00, ists_q};
    assign mask_rd_w = {5'h00, irq_mask_q};
    assign gctl_rd_w = 8'(gate_q) << ssirq_pkg::GC_GATE_BIT;
    // live sense and the combined status are read straight, never stored
    assign scsi_rd_w = {port_irq_w, rst_irq_q, i_scsi_bus_reset_sense,
        scsi_ctrl_q[4:0]};
    // unmapped addresses read zero alongside the error reply
    assign rd_w = hit_gen_w ? gen_rd_w
        : hit_scsi_w ? scsi_rd_w
        : hit_base_w ? slave_base_q
        : hit_ists_w ? ists_rd_w
        : hit_mask_w ? mask_rd_w
        : hit_gctl_w ? gctl_rd_w
        : 8'h00;

    // answer is prepared in the setup cycle so pready can come from a flop
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end else begin
            o_pready <= setup_w;
            if (setup_w) begin
                o_pslverr <= ~mapped_w;
                o_prdata <= {24'h000000, rd_w};
            end else begin
                o_pslverr <= 1'b0;
                o_prdata <= 32'h0;
            end
        end
    end
endmodule
`default_nettype wire

// [ssirq_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
// checker on the top ports; mirrors only the few register fields it needs
module ssirq_asserts (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [31:0] o_prdata,
    // board side
    input wire logic i_scsi_bus_reset_sense,
    input wire logic i_scsi_chip_irq,
    input wire logic o_scsi_bus_reset_drive,
    input wire logic [2:0] o_scsi_irq_level,
    input wire logic o_irq,
    input wire logic [31:0] o_win_start,
    input wire logic [31:0] o_win_last
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    localparam logic [31:0] A_SC = ssirq_pkg::IDX_SCSI_CTRL << 2;
    localparam logic [31:0] A_SB = ssirq_pkg::IDX_SLAVE_BASE << 2;
    localparam logic [31:0] A_GC = ssirq_pkg::IDX_GLOBAL_CTRL << 2;
    // committed writes and read setups, decoded by byte address
    wire logic wr = i_psel && i_penable && i_pwrite && o_pready;
    wire logic wr_ctl = wr && (i_paddr == A_SC);
    wire logic wr_sb = wr && (i_paddr == A_SB);
    wire logic wr_gc = wr && (i_paddr == A_GC);
    wire logic rd_ctl = i_psel && !i_penable && !i_pwrite && (i_paddr == A_SC);
    logic gate_q;
    logic drv_q;
    logic [2:0] lvl_q;
    logic [4:0] base_q;
    // shadow copies follow the same committing edge as the block
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gate_q <= 1'b0;
            drv_q <= 1'b0;
            lvl_q <= 3'h0;
            base_q <= 5'h00;
        end else begin
            if (wr_gc) gate_q <= i_pwdata[ssirq_pkg::GC_GATE_BIT];
            if (wr_ctl) drv_q <= i_pwdata[4];
            if (wr_ctl) lvl_q <= i_pwdata[2:0];
            if (wr_sb) base_q <= i_pwdata[4:0];
        end
    end
    // a write followed by two quiet cycles, long enough for outputs to land
    sequence s_settled(w);
        w ##1 !w ##1 !w;
    endsequence
    sequence s_chip_held;
        (i_scsi_chip_irq && gate_q && $stable(lvl_q) && $stable(gate_q))[*3];
    endsequence
    property p_ready_after_setup;
        i_psel && !i_penable |=> o_pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no pready after setup");
    property p_err_with_ready;
        o_pslverr |-> o_pready && o_prdata == 32'h00000000;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("bad error reply");
    property p_upper_zero;
        o_prdata[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_drive_value;
        s_settled(wr_ctl) |-> o_scsi_bus_reset_drive == drv_q;
    endproperty
    a_drive_value: assert property (p_drive_value) else $error("drive not as written");
    property p_drive_hold;
        !wr_ctl && !$past(wr_ctl) && !$past(wr_ctl, 2) |-> $stable(o_scsi_bus_reset_drive);
    endproperty
    a_drive_hold: assert property (p_drive_hold) else $error("drive moved unasked");
    property p_window;
        s_settled(wr_sb) |-> o_win_start == ({27'h0, base_q} << ssirq_pkg::MEM_SPAN_LOG2)
            && o_win_last == o_win_start + (32'h1 << ssirq_pkg::MEM_SPAN_LOG2) - 32'h1;
    endproperty
    a_window: assert property (p_window) else $error("slave window wrong");
    property p_gate_blocks;
        !gate_q && !$past(gate_q) && !$past(gate_q, 2) |-> !o_irq && o_scsi_irq_level == 3'h0;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("request while gate off");
    property p_chip_level;
        s_chip_held |-> o_scsi_irq_level == lvl_q;
    endproperty
    a_chip_level: assert property (p_chip_level) else $error("chip irq level wrong");
    property p_sense_read;
        $stable(i_scsi_bus_reset_sense)[*3] ##0 rd_ctl |=> o_prdata[5] == $past(i_scsi_bus_reset_sense);
    endproperty
    a_sense_read: assert property (p_sense_read) else $error("sense bit wrong");
endmodule
bind ssirq_top ssirq_asserts u_asserts (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_prdata, .i_scsi_bus_reset_sense,
    .i_scsi_chip_irq, .o_scsi_bus_reset_drive, .o_scsi_irq_level, .o_irq, .o_win_start,
    .o_win_last);
`default_nettype wire

// [ssirq_scsi_bus.sv]
`timescale 1ns/100ps
`default_nettype none
// scsi bus side: wired-or reset line and the controller chip request
module ssirq_scsi_bus (
    // clock
    input wire logic i_clk,
    // pullers of the reset line and chip request
    input wire logic i_drive,
    input wire logic i_other_reset,
    input wire logic i_chip_req,
    // lines seen by the block
    output logic o_reset_line,
    output logic o_chip_irq
);
    logic line_q = 1'b0;
    logic chip_q = 1'b0;
    // any initiator may pull reset, so the line is the or of all of them
    always @(posedge i_clk) begin
        line_q <= i_drive | i_other_reset;
        chip_q <= i_chip_req;
    end
    assign o_reset_line = line_q;
    assign o_chip_irq = chip_q;
endmodule
`default_nettype wire

// [status_scsi_irq_slave_base_regs_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module status_scsi_irq_slave_base_regs_tb;
    localparam logic [31:0] A_GS = ssirq_pkg::IDX_GEN_STATUS << 2;
    localparam logic [31:0] A_SC = ssirq_pkg::IDX_SCSI_CTRL << 2;
    localparam logic [31:0] A_SB = ssirq_pkg::IDX_SLAVE_BASE << 2;
    localparam logic [31:0] A_IS = ssirq_pkg::IDX_IRQ_STATUS << 2;
    localparam logic [31:0] A_IM = ssirq_pkg::IDX_IRQ_MASK << 2;
    localparam logic [31:0] A_GC = ssirq_pkg::IDX_GLOBAL_CTRL << 2;
    logic clk, rst_n, por_n, psel, penable, pwrite, par, ext_rst, chip_req;
    logic pready, pslverr, drive, sense, chip, irq, lockw, err;
    logic [31:0] paddr, pwdata, prdata, rdata, ws, wl;
    logic [2:0] lvl;
    logic [1:0] nethi;
    logic [7:0] sel [4] = '{8'h00, 8'h01, 8'h0D, 8'hFF};
    int n_mismatch, num_checks;
    ssirq_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata), .i_mem_parity_fault(par),
        .i_scsi_bus_reset_sense(sense), .i_scsi_chip_irq(chip), .o_scsi_bus_reset_drive(drive),
        .o_scsi_irq_level(lvl), .o_irq(irq), .o_win_start(ws), .o_win_last(wl),
        .o_locked_cycle_wait_ctl(lockw), .o_net_dma_addr_hi(nethi));
    ssirq_scsi_bus u_bus (.i_clk(clk), .i_drive(drive), .i_other_reset(ext_rst),
        .i_chip_req(chip_req), .o_reset_line(sense), .o_chip_irq(chip));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic close_out;
        if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; an idle cycle follows so psel is never reassigned at once
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
            close_out();
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rchk(input logic [31:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdata, {24'h0, exp});
    endtask
    // outputs and the bus model each add a flop stage, so allow a few cycles
    task automatic settle;
        repeat (4) @(posedge clk);
    endtask
    task automatic rst_pulse;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic pulse_par;
        par <= 1'b1;
        @(posedge clk);
        par <= 1'b0;
        settle();
    endtask
    initial begin
        {rst_n, por_n, psel, penable, pwrite, par, ext_rst, chip_req} = 8'h00;
        paddr = 32'h0;
        pwdata = 32'h0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (4) @(posedge clk);
        // reset values, unmapped access, power-on flag survives system reset
        rchk(A_GS, 8'h02);
        rchk(A_SC, 8'h00);
        rchk(A_SB, 8'h00);
        xfer(1'b0, A_GC + 32'h4, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(A_GS, 32'h00);
        rchk(A_GS, 8'h02);
        rst_pulse();
        rchk(A_GS, 8'h02);
        wr(A_GS, 32'h02);
        rchk(A_GS, 8'h00);
        // parity flag: set by event, cleared by write-one and by reset
        pulse_par();
        rchk(A_GS, 8'h01);
        wr(A_GS, 32'h01);
        rchk(A_GS, 8'h00);
        pulse_par();
        rst_pulse();
        rchk(A_GS, 8'h00);
        // slave window at the ends of the select field
        foreach (sel[i]) begin
            wr(A_SB, {24'h0, sel[i]});
            settle();
            rchk(A_SB, sel[i]);
            chk(ws, {27'h0, sel[i][4:0]} << ssirq_pkg::MEM_SPAN_LOG2);
            chk(wl, (({27'h0, sel[i][4:0]} + 32'h1) << ssirq_pkg::MEM_SPAN_LOG2) - 32'h1);
            chk({31'h0, lockw}, {31'h0, sel[i][5]});
            chk({30'h0, nethi}, {30'h0, sel[i][7:6]});
        end
        rst_pulse();
        rchk(A_SB, 8'h00);
        chk(ws, 32'h0);
        chk({31'h0, lockw}, 32'h0);
        chk({30'h0, nethi}, 32'h0);
        // whole-byte writes only: a read-modify-write would clear a pending latch
        wr(A_GC, 32'h10);
        rchk(A_GC, 8'h10);
        wr(A_SC, 32'h1D);
        settle();
        chk({31'h0, drive}, 32'h1);
        rchk(A_SC, 8'hFD);
        chk({29'h0, lvl}, 32'h5);
        wr(A_SC, 32'h5D);
        settle();
        rchk(A_SC, 8'h3D);
        chk({29'h0, lvl}, 32'h0);
        chip_req <= 1'b1;
        settle();
        rchk(A_SC, 8'hBD);
        chk({29'h0, lvl}, 32'h5);
        wr(A_SC, 32'h18);
        settle();
        chk({29'h0, lvl}, 32'h0);
        chip_req <= 1'b0;
        wr(A_SC, 32'h0D);
        settle();
        ext_rst <= 1'b1;
        settle();
        rchk(A_SC, 8'hED);
        wr(A_SC, 32'h05);
        settle();
        rchk(A_SC, 8'h25);
        ext_rst <= 1'b0;
        settle();
        rchk(A_SC, 8'h05);
        // interrupt output: status, mask and global gate
        rchk(A_IS, 8'h06);
        wr(A_IS, 32'h07);
        pulse_par();
        rchk(A_IS, 8'h01);
        chk({31'h0, irq}, 32'h0);
        wr(A_IM, 32'h01);
        settle();
        chk({31'h0, irq}, 32'h1);
        wr(A_GC, 32'hEF);
        settle();
        chk({31'h0, irq}, 32'h0);
        rchk(A_GC, 8'h00);
        wr(A_GC, 32'h10);
        wr(A_IS, 32'h01);
        settle();
        chk({31'h0, irq}, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
